// ---- pkg/filter_status_cfg.svh ----
// Register addresses, field positions and fixed values of the status bank
`ifndef FILTER_STATUS_CFG_SVH
`define FILTER_STATUS_CFG_SVH

// Single-word registers
`define ADDR_OWN_NODE_ID 16'h0034
`define ADDR_ONLINE_NODE_COUNT 16'h0035
`define ADDR_RUNNING_NODE_COUNT 16'h0036
`define ADDR_CURRENT_MASTER_ID 16'h0037

// Two-word registers, high half at the base address
`define ADDR_NEUTRAL_OUTPUT_CURRENT 16'h0038
`define ADDR_NEUTRAL_SENSED_CURRENT 16'h003a
`define ADDR_NEUTRAL_VOLTAGE 16'h003c
`define ADDR_VOLTAGE_DISTORTION_AVG 16'h003e
`define ADDR_CURRENT_DISTORTION_AVG 16'h0040
`define ADDR_POWER_FACTOR_VALUE 16'h0042
`define ADDR_DISPLACEMENT_FACTOR 16'h0044
`define ADDR_ALARM_FLAGS_FIRST 16'h0046
`define ADDR_ALARM_FLAGS_SECOND 16'h0048
`define ADDR_ALARM_FLAGS_THIRD 16'h004a
`define ADDR_WARNING_FLAGS 16'h004c

// Pair block layout
`define PAIR_FIRST_ADDR 16'h0038
`define PAIR_LAST_ADDR 16'h004d
`define PAIR_COUNT 11
`define PAIR_IDX_ALARM1 7
`define PAIR_IDX_ALARM2 8
`define PAIR_IDX_ALARM3 9
`define PAIR_IDX_WARN 10

// Fixed values
`define MASTER_ID_NONE 16'h000f
`define NODE_COUNT_DISABLED 16'h0000
`define ALARM1_DEFINED_BITS 32'h0000_0001

// Warning mask bit positions
`define WARN_BIT_MODULE_TEMP 0
`define WARN_BIT_AMBIENT_TEMP 1
`define WARN_BIT_NO_MASTER 2
`define WARN_BIT_POWER_STAGE 3
`define WARN_BIT_MEMORY_CARD 4

// Second alarm mask bit positions
`define ALARM2_BIT_OC_1_3 0
`define ALARM2_BIT_DC_UV_1 1
`define ALARM2_BIT_DC_OV_1 2
`define ALARM2_BIT_OC_4_6 3
`define ALARM2_BIT_DC_UV_4 4
`define ALARM2_BIT_DC_OV_4 5
`define ALARM2_BIT_WATCHDOG 6

// Third alarm mask bit positions
`define ALARM3_BIT_PHASE_ORDER 0
`define ALARM3_BIT_AC_UV 1
`define ALARM3_BIT_AC_OV 2
`define ALARM3_BIT_PRECHARGE 3
`define ALARM3_BIT_AMBIENT_OT 4
`define ALARM3_BIT_TEMP_DIFF 5
`define ALARM3_BIT_MODULE_OT 6
`define ALARM3_BIT_EXTERNAL 7
`define ALARM3_BIT_STARTUP 8
`define ALARM3_BIT_LIMITATION 9
`define ALARM3_BIT_PHASE_LOSS 10

// Populated widths of the alarm and warning masks
`define ALARM2_WIDTH 7
`define ALARM3_WIDTH 11
`define WARN_WIDTH 5

`endif

// ---- pkg/filter_status_pkg.sv ----
// Types shared by the status register bank modules
package filter_status_pkg;
   typedef logic [15:0] word16_type;
   typedef logic [31:0] word32_type;
   typedef enum logic [0:0] {PORT_IDLE, PORT_ANSWER} port_state_type;
endpackage

// ---- pkg/status_view_if.sv ----
// Snapshot of all status values passed from the bank to its address decoder
`timescale 1ns/100ps
`default_nettype none
interface status_view_if;
   import filter_status_pkg::*;
   word16_type own_id;
   word16_type online;
   word16_type running;
   word16_type master;
   word32_type pair_val [0:10];
   modport source (output own_id, output online, output running, output master,
                   output pair_val);
   modport sink (input own_id, input online, input running, input master,
                 input pair_val);
endinterface
`default_nettype wire

// ---- core/node_state_track.sv ----
// Multi-master bus state reporting: counts, master identity, no-master warning
`timescale 1ns/100ps
`default_nettype none
`include "filter_status_cfg.svh"
module node_state_track
   import filter_status_pkg::*;
(
   input wire logic mm_enable,
   input wire logic [15:0] nodes_online_in,
   input wire logic [15:0] nodes_running_in,
   input wire logic master_present,
   input wire logic [15:0] master_id_in,
   output logic [15:0] online_rep,
   output logic [15:0] running_rep,
   output logic [15:0] master_rep,
   output logic no_master
);
   // Online count doubles as the feature-disabled indicator
   assign online_rep = mm_enable ? nodes_online_in : `NODE_COUNT_DISABLED; // R1
   assign running_rep = mm_enable ? nodes_running_in : `NODE_COUNT_DISABLED; // R2
   // Absent master forces the reserved identifier, whatever the bus says
   assign no_master = !(mm_enable && master_present);
   assign master_rep = no_master ? `MASTER_ID_NONE : master_id_in; // R3
endmodule // node_state_track
`default_nettype wire

// ---- core/status_decode.sv ----
// Address decode of the status bank: selects a word or a word pair
`timescale 1ns/100ps
`default_nettype none
`include "filter_status_cfg.svh"
module status_decode
   import filter_status_pkg::*;
(
   status_view_if.sink view,
   input wire logic [15:0] addr,
   output logic hit,
   output logic is_pair,
   output logic low_half,
   output logic [31:0] value
);
   // Index of the pair that holds an address inside the pair block
   function automatic logic [3:0] pair_index(input logic [15:0] a);
      logic [15:0] off;
      off = a - `PAIR_FIRST_ADDR;
      pair_index = off[4:1];
   endfunction

   // Word or pair selection
   always_comb begin
      hit = 1'b1;
      is_pair = 1'b0;
      low_half = addr[0]; // R4
      value = 32'h0000_0000;
      case (addr)
         `ADDR_OWN_NODE_ID: value = {16'h0000, view.own_id}; // R9
         `ADDR_ONLINE_NODE_COUNT: value = {16'h0000, view.online}; // R1
         `ADDR_RUNNING_NODE_COUNT: value = {16'h0000, view.running}; // R2
         `ADDR_CURRENT_MASTER_ID: value = {16'h0000, view.master}; // R3
         default: begin
            if (addr >= `PAIR_FIRST_ADDR && addr <= `PAIR_LAST_ADDR) begin
               is_pair = 1'b1;
               value = view.pair_val[pair_index(addr)]; // R5
            end else begin
               hit = 1'b0;
            end
         end
      endcase
   end
endmodule // status_decode
`default_nettype wire

// ---- core/filter_status_register_bank.sv ----
// Read-only status register bank of the filter, served over a register read port
// What this block does
// [R1] Online node count register reads zero while the multi-master feature is off.
// [R2] Running node count has its own 16-bit register.
// [R3] Current master identifier register reads 15 when no master exists.
// [R4] 32-bit values use two registers, upper half at the lower address.
// [R5] Float pairs: neutral currents, neutral voltage, distortion, power factor, cos phi.
// [R6] Second alarm mask bits 0-6 carry the listed power stage alarms.
// [R7] Third alarm mask bits 0-10 carry the listed AC and module alarms.
// [R8] Warning mask bits 0-4 carry the listed warnings, bit 2 no master.
// [R9] Own node identifier sits just below the online node count.
// [R10] Undefined mask bits read zero; writes to this bank change nothing.
`timescale 1ns/100ps
`default_nettype none
`include "filter_status_cfg.svh"
module filter_status_register_bank
   import filter_status_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   // Multi-master bus state
   input wire logic mm_enable,
   input wire logic [15:0] own_node_identifier,
   input wire logic [15:0] nodes_online_in,
   input wire logic [15:0] nodes_running_in,
   input wire logic master_present,
   input wire logic [15:0] master_id_in,
   // Measurements, IEEE single precision
   input wire logic [31:0] neutral_output_current_in,
   input wire logic [31:0] neutral_sensed_current_in,
   input wire logic [31:0] neutral_voltage_in,
   input wire logic [31:0] voltage_distortion_in,
   input wire logic [31:0] current_distortion_in,
   input wire logic [31:0] power_factor_in,
   input wire logic [31:0] displacement_factor_in,
   // Alarm sources
   input wire logic [31:0] alarm_first_in,
   input wire logic overcurrent_stage_1_3,
   input wire logic dc_undervolt_stage_1,
   input wire logic dc_overvolt_stage_1,
   input wire logic overcurrent_stage_4_6,
   input wire logic dc_undervolt_stage_4,
   input wire logic dc_overvolt_stage_4,
   input wire logic watchdog_error,
   input wire logic phase_order_wrong,
   input wire logic ac_undervolt,
   input wire logic ac_overvolt,
   input wire logic precharge_error,
   input wire logic ambient_overtemp,
   input wire logic module_temp_diff,
   input wire logic module_overtemp,
   input wire logic external_alarm,
   input wire logic startup_error,
   input wire logic limitation_error,
   input wire logic ac_phase_loss,
   // Warning sources
   input wire logic module_temp_high,
   input wire logic ambient_temp_high,
   input wire logic power_stage_abnormal,
   input wire logic memory_card_missing,
   // Register read port
   input wire logic [15:0] reg_addr,
   input wire logic rd_req,
   input wire logic wr_req,
   output logic rd_ack,
   output logic [15:0] rd_data,
   output logic addr_err,
   output logic wr_refused
);
   status_view_if view ();

   // Multi-master bus values after the reporting rules
   logic [15:0] online_rep;
   logic [15:0] running_rep;
   logic [15:0] master_rep;
   logic no_master;

   // Snapshot registers read by the decoder
   logic [15:0] own_id_r;
   logic [15:0] online_r;
   logic [15:0] running_r;
   logic [15:0] master_r;
   logic [31:0] pair_r [0:10];

   // Values the snapshots load on the next edge
   logic [31:0] alarm2_nxt;
   logic [31:0] alarm3_nxt;
   logic [31:0] warn_nxt;
   logic [31:0] pair_nxt [0:10];

   // Read port sequencing and latched request
   port_state_type port_state_r;
   port_state_type port_state_nxt;
   logic [15:0] req_addr_r;
   logic req_is_write_r;

   // Decoder answer for the latched address
   logic dec_hit;
   logic dec_is_pair;
   logic dec_low_half;
   logic [31:0] dec_value;

   // Low half kept for a following pair read
   logic [15:0] hold_data_r;
   logic [15:0] hold_addr_r;
   logic hold_valid_r;
   logic [15:0] word_nxt;
   logic hold_match;

   // Counts and master identity with the feature-off and no-master rules applied
   node_state_track u_nodes (
      .mm_enable(mm_enable),
      .nodes_online_in(nodes_online_in),
      .nodes_running_in(nodes_running_in),
      .master_present(master_present),
      .master_id_in(master_id_in),
      .online_rep(online_rep),
      .running_rep(running_rep),
      .master_rep(master_rep),
      .no_master(no_master)
   );

   // Mask assembly; all unnamed positions are tied to zero
   always_comb begin
      alarm2_nxt = 32'h0000_0000;
      alarm3_nxt = 32'h0000_0000;
      warn_nxt = 32'h0000_0000;
      // Power stage alarms, one named position each so a reorder cannot slip in
      alarm2_nxt[`ALARM2_BIT_OC_1_3] = overcurrent_stage_1_3; // R6
      alarm2_nxt[`ALARM2_BIT_DC_UV_1] = dc_undervolt_stage_1; // R6
      alarm2_nxt[`ALARM2_BIT_DC_OV_1] = dc_overvolt_stage_1; // R6
      alarm2_nxt[`ALARM2_BIT_OC_4_6] = overcurrent_stage_4_6; // R6
      alarm2_nxt[`ALARM2_BIT_DC_UV_4] = dc_undervolt_stage_4; // R6
      alarm2_nxt[`ALARM2_BIT_DC_OV_4] = dc_overvolt_stage_4; // R6
      alarm2_nxt[`ALARM2_BIT_WATCHDOG] = watchdog_error; // R6
      // AC side and module alarms
      alarm3_nxt[`ALARM3_BIT_PHASE_ORDER] = phase_order_wrong; // R7
      alarm3_nxt[`ALARM3_BIT_AC_UV] = ac_undervolt; // R7
      alarm3_nxt[`ALARM3_BIT_AC_OV] = ac_overvolt; // R7
      alarm3_nxt[`ALARM3_BIT_PRECHARGE] = precharge_error; // R7
      alarm3_nxt[`ALARM3_BIT_AMBIENT_OT] = ambient_overtemp; // R7
      alarm3_nxt[`ALARM3_BIT_TEMP_DIFF] = module_temp_diff; // R7
      alarm3_nxt[`ALARM3_BIT_MODULE_OT] = module_overtemp; // R7
      alarm3_nxt[`ALARM3_BIT_EXTERNAL] = external_alarm; // R7
      alarm3_nxt[`ALARM3_BIT_STARTUP] = startup_error; // R7
      alarm3_nxt[`ALARM3_BIT_LIMITATION] = limitation_error; // R7
      alarm3_nxt[`ALARM3_BIT_PHASE_LOSS] = ac_phase_loss; // R7
      // Warnings; the no-master bit follows the bus state, not a pin
      warn_nxt[`WARN_BIT_MODULE_TEMP] = module_temp_high; // R8
      warn_nxt[`WARN_BIT_AMBIENT_TEMP] = ambient_temp_high; // R8
      warn_nxt[`WARN_BIT_NO_MASTER] = no_master; // R8
      warn_nxt[`WARN_BIT_POWER_STAGE] = power_stage_abnormal; // R8
      warn_nxt[`WARN_BIT_MEMORY_CARD] = memory_card_missing; // R8
   end

   // Pair table in address order, one entry per two-word register
   always_comb begin
      pair_nxt[0] = neutral_output_current_in; // R5
      pair_nxt[1] = neutral_sensed_current_in; // R5
      pair_nxt[2] = neutral_voltage_in; // R5
      pair_nxt[3] = voltage_distortion_in; // R5
      pair_nxt[4] = current_distortion_in; // R5
      pair_nxt[5] = power_factor_in; // R5
      pair_nxt[6] = displacement_factor_in; // R5
      pair_nxt[`PAIR_IDX_ALARM1] = alarm_first_in & `ALARM1_DEFINED_BITS; // R10
      pair_nxt[`PAIR_IDX_ALARM2] = alarm2_nxt;
      pair_nxt[`PAIR_IDX_ALARM3] = alarm3_nxt;
      pair_nxt[`PAIR_IDX_WARN] = warn_nxt;
   end

   // Single-word snapshot, refreshed every cycle
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         own_id_r <= 16'h0000;
         online_r <= 16'h0000;
         running_r <= 16'h0000;
         master_r <= `MASTER_ID_NONE;
      end else begin
         own_id_r <= own_node_identifier; // R9
         online_r <= online_rep; // R1
         running_r <= running_rep; // R2
         master_r <= master_rep; // R3
      end
   end

   // Pair snapshot; registering every value keeps the read path short
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < `PAIR_COUNT; i++) begin
            pair_r[i] <= 32'h0000_0000;
         end
      end else begin
         for (int i = 0; i < `PAIR_COUNT; i++) begin
            pair_r[i] <= pair_nxt[i];
         end
      end
   end

   // Feed the decoder view
   assign view.own_id = own_id_r;
   assign view.online = online_r;
   assign view.running = running_r;
   assign view.master = master_r;
   always_comb begin
      for (int i = 0; i < `PAIR_COUNT; i++) begin
         view.pair_val[i] = pair_r[i];
      end
   end

   // Decoder looks at the latched request address
   status_decode u_decode (
      .view(view),
      .addr(req_addr_r),
      .hit(dec_hit),
      .is_pair(dec_is_pair),
      .low_half(dec_low_half),
      .value(dec_value)
   );

   // Port sequencing: take a request when idle, answer on the next cycle
   always_comb begin
      case (port_state_r)
         PORT_IDLE: port_state_nxt = (rd_req || wr_req) ? PORT_ANSWER : PORT_IDLE;
         PORT_ANSWER: port_state_nxt = PORT_IDLE;
         default: port_state_nxt = PORT_IDLE;
      endcase
   end

   // State register of the read port
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         port_state_r <= PORT_IDLE;
      end else begin
         port_state_r <= port_state_nxt;
      end
   end

   // Request capture; a read wins if both strobes come together
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         req_addr_r <= 16'h0000;
         req_is_write_r <= 1'b0;
      end else if (port_state_r == PORT_IDLE && (rd_req || wr_req)) begin
         req_addr_r <= reg_addr;
         req_is_write_r <= !rd_req;
      end
   end

   // A low half read straight after its high half returns the half caught
   // with it, so a value updating between the two reads never tears
   assign hold_match = hold_valid_r && (hold_addr_r == req_addr_r);

   always_comb begin
      if (!dec_hit) begin
         word_nxt = 16'h0000;
      end else if (!dec_is_pair) begin
         word_nxt = dec_value[15:0];
      end else if (dec_low_half) begin
         word_nxt = hold_match ? hold_data_r : dec_value[15:0]; // R4
      end else begin
         word_nxt = dec_value[31:16]; // R4
      end
   end

   // Low-half hold, armed by a high-half read, dropped by any other access
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         hold_data_r <= 16'h0000;
         hold_addr_r <= 16'h0000;
         hold_valid_r <= 1'b0;
      end else if (port_state_r == PORT_ANSWER) begin
         if (!req_is_write_r && dec_hit && dec_is_pair && !dec_low_half) begin
            hold_data_r <= dec_value[15:0];
            hold_addr_r <= req_addr_r + 16'h0001;
            hold_valid_r <= 1'b1;
         end else begin
            hold_valid_r <= 1'b0;
         end
      end
   end

   // Answer outputs; writes are acknowledged, refused and store nothing
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rd_data <= 16'h0000;
         addr_err <= 1'b0;
         wr_refused <= 1'b0;
      end else if (port_state_r == PORT_ANSWER) begin
         rd_data <= req_is_write_r ? 16'h0000 : word_nxt;
         addr_err <= !dec_hit;
         wr_refused <= req_is_write_r; // R10
      end
   end

   // Acknowledge pulse lines up with the registered answer
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rd_ack <= 1'b0;
      end else begin
         rd_ack <= (port_state_r == PORT_ANSWER);
      end
   end
endmodule // filter_status_register_bank
`default_nettype wire

// ---- test/filter_status_properties.sv ----
// Concurrent checks on the ports of the filter status register bank
`timescale 1ns/100ps
`default_nettype none
module filter_status_checker (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic mm_enable,
   input wire logic master_present,
   input wire logic [15:0] own_node_identifier,
   input wire logic [15:0] nodes_running_in,
   input wire logic [15:0] reg_addr,
   input wire logic rd_req,
   input wire logic wr_req,
   input wire logic rd_ack,
   input wire logic [15:0] rd_data,
   input wire logic addr_err,
   input wire logic wr_refused
);
   logic busy_r;
   logic taken;
   // Mirror of the port state; requests in the answer cycle are ignored
   assign taken = (rd_req || wr_req) && !busy_r;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         busy_r <= 1'b0;
      end else begin
         busy_r <= taken;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   a_answer_latency: assert property (taken |=> !rd_ack ##1 rd_ack)
      else $error("answer not two cycles after request");
   a_ack_single: assert property (rd_ack |=> !rd_ack)
      else $error("answer pulse longer than one cycle");
   a_ack_cause: assert property (rd_ack |-> $past(taken, 2))
      else $error("answer without request");
   a_write_refused: assert property (taken && wr_req && !rd_req |-> ##2
      rd_ack && wr_refused && rd_data == 16'h0000)
      else $error("write not refused");
   a_unmapped_err: assert property (taken && (reg_addr < 16'h0034 || reg_addr > 16'h004d)
      |-> ##2 addr_err && rd_data == 16'h0000)
      else $error("unmapped address not flagged");
   a_online_off: assert property (taken && rd_req && reg_addr == 16'h0035 && !mm_enable
      |-> ##2 rd_data == 16'h0000)
      else $error("online count not zero when feature off");
   a_master_none: assert property (taken && rd_req && reg_addr == 16'h0037 && !master_present
      |-> ##2 rd_data == 16'h000f)
      else $error("master id not 15 without master");
   a_running_value: assert property (taken && rd_req && reg_addr == 16'h0036 && mm_enable
      |-> ##2 rd_data == $past(nodes_running_in, 2))
      else $error("running count wrong");
   a_own_id: assert property (taken && rd_req && reg_addr == 16'h0034
      |-> ##2 rd_data == $past(own_node_identifier, 2))
      else $error("own node id wrong");
   a_data_holds: assert property (!rd_ack |-> $stable(rd_data))
      else $error("read data changed without answer");
endmodule // filter_status_checker
`default_nettype wire

// ---- test/status_client_model.sv ----
// Remote client model issuing single register accesses on the read port
`timescale 1ns/100ps
`default_nettype none
module status_client_model (
   input wire logic mclk,
   input wire logic rd_ack,
   input wire logic [15:0] rd_data,
   input wire logic addr_err,
   input wire logic wr_refused,
   output logic [15:0] reg_addr,
   output logic rd_req,
   output logic wr_req
);
   initial begin
      reg_addr = 16'h0000;
      rd_req = 1'b0;
      wr_req = 1'b0;
   end
   // Request lasts one taking edge; holding it past the next edge would be taken twice
   task automatic access(input logic [15:0] a, input logic wr, input int gap,
      output logic [18:0] ans);
      int k;
      repeat (gap + 1) @(posedge mclk);
      reg_addr <= a;
      rd_req <= !wr;
      wr_req <= wr;
      @(posedge mclk);
      reg_addr <= ~a; // Released address shows no stale value
      rd_req <= 1'b0;
      wr_req <= 1'b0;
      k = 0;
      do begin
         @(posedge mclk);
         k++;
      end while (rd_ack !== 1'b1 && k < 6);
      ans = {rd_ack, addr_err, wr_refused, rd_data};
   endtask
endmodule // status_client_model
`default_nettype wire

// ---- test/testbench.sv ----
// Top-level bench for the filter status register bank
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic mclk, rst_b, mm_enable, master_present, rd_req, wr_req, rd_ack, addr_err, wr_refused;
   logic [15:0] own_id, online, running, master_id, reg_addr, rd_data;
   logic [31:0] m [0:6];
   logic [31:0] alarm1;
   logic [21:0] fl, fv;
   int n_fail, n_compared, i, gap;

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   filter_status_register_bank filter_status_register_bank_inst (
      .mclk(mclk), .rst_b(rst_b), .mm_enable(mm_enable), .own_node_identifier(own_id),
      .nodes_online_in(online), .nodes_running_in(running), .master_present(master_present),
      .master_id_in(master_id), .neutral_output_current_in(m[0]),
      .neutral_sensed_current_in(m[1]), .neutral_voltage_in(m[2]),
      .voltage_distortion_in(m[3]), .current_distortion_in(m[4]), .power_factor_in(m[5]),
      .displacement_factor_in(m[6]), .alarm_first_in(alarm1), .overcurrent_stage_1_3(fl[0]),
      .dc_undervolt_stage_1(fl[1]), .dc_overvolt_stage_1(fl[2]), .overcurrent_stage_4_6(fl[3]),
      .dc_undervolt_stage_4(fl[4]), .dc_overvolt_stage_4(fl[5]), .watchdog_error(fl[6]),
      .phase_order_wrong(fl[7]), .ac_undervolt(fl[8]), .ac_overvolt(fl[9]),
      .precharge_error(fl[10]), .ambient_overtemp(fl[11]), .module_temp_diff(fl[12]),
      .module_overtemp(fl[13]), .external_alarm(fl[14]), .startup_error(fl[15]),
      .limitation_error(fl[16]), .ac_phase_loss(fl[17]), .module_temp_high(fl[18]),
      .ambient_temp_high(fl[19]), .power_stage_abnormal(fl[20]),
      .memory_card_missing(fl[21]), .reg_addr(reg_addr), .rd_req(rd_req), .wr_req(wr_req),
      .rd_ack(rd_ack), .rd_data(rd_data), .addr_err(addr_err), .wr_refused(wr_refused));

   status_client_model status_client_model_inst (
      .mclk(mclk), .rd_ack(rd_ack), .rd_data(rd_data), .addr_err(addr_err),
      .wr_refused(wr_refused), .reg_addr(reg_addr), .rd_req(rd_req), .wr_req(wr_req));

   task chk(input logic [18:0] got, input logic [18:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One access; expected word is {ack, error, refused, data}
   task xfer(input logic [15:0] a, input logic w, input logic [18:0] e);
      logic [18:0] ans;
      status_client_model_inst.access(a, w, gap, ans);
      chk(ans, e);
   endtask

   task print_verdict;
      $display("compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Watchdog: the whole sequence needs about 450 cycles
   initial begin
      repeat (20000) @(posedge mclk);
      n_fail++;
      print_verdict;
   end

   initial begin
      rst_b = 1'b0;
      mm_enable = 1'b1;
      master_present = 1'b1;
      own_id = 16'h00a5;
      online = 16'h0003;
      running = 16'h0002;
      master_id = 16'h0006;
      alarm1 = 32'h0000_0000;
      fl = 22'h000000;
      gap = 0;
      for (i = 0; i < 7; i++) begin
         m[i] = 32'h41a0_5c00 + 32'h0111_0023 * i;
      end
      repeat (20) @(posedge mclk);
      chk({rd_ack, addr_err, wr_refused, rd_data}, 19'h00000);
      rst_b <= 1'b1;
      // Single words, then feature off, then no master present
      xfer(16'h0034, 1'b0, {3'b100, 16'h00a5});
      xfer(16'h0035, 1'b0, {3'b100, 16'h0003});
      xfer(16'h0036, 1'b0, {3'b100, 16'h0002});
      xfer(16'h0037, 1'b0, {3'b100, 16'h0006});
      mm_enable <= 1'b0;
      xfer(16'h0035, 1'b0, {3'b100, 16'h0000});
      xfer(16'h0037, 1'b0, {3'b100, 16'h000f});
      mm_enable <= 1'b1;
      master_present <= 1'b0;
      xfer(16'h0037, 1'b0, {3'b100, 16'h000f});
      xfer(16'h004d, 1'b0, {3'b100, 16'h0004});
      master_present <= 1'b1;
      $display("test words done");
      // Float pairs in address order, then a low half held with its high half
      for (i = 0; i < 7; i++) begin
         xfer(16'(16'h0038 + 2 * i), 1'b0, {3'b100, m[i][31:16]});
         xfer(16'(16'h0039 + 2 * i), 1'b0, {3'b100, m[i][15:0]});
      end
      xfer(16'h0038, 1'b0, {3'b100, m[0][31:16]});
      m[0] <= m[0] ^ 32'h0000_ffff;
      xfer(16'h0039, 1'b0, {3'b100, m[0][15:0]});
      xfer(16'h0039, 1'b0, {3'b100, m[0][15:0]});
      $display("test pairs done");
      // Walk one set source across every pin-driven position of the second and third alarm and warning masks
      for (i = 0; i < 22; i++) begin
         fv = 22'h000001 << i;
         fl <= fv;
         xfer(16'h0049, 1'b0, {3'b100, 9'h000, fv[6:0]});
         xfer(16'h004b, 1'b0, {3'b100, 5'h00, fv[17:7]});
         xfer(16'h004d, 1'b0, {3'b100, 11'h000, fv[21:20], 1'b0, fv[19:18]});
      end
      $display("test masks done");
      // All pin-driven sources set: undefined positions still read zero
      fl <= 22'h3fffff;
      alarm1 <= 32'hffff_ffff;
      xfer(16'h0046, 1'b0, {3'b100, 16'h0000});
      xfer(16'h0047, 1'b0, {3'b100, 16'h0001});
      xfer(16'h0048, 1'b0, {3'b100, 16'h0000});
      xfer(16'h0049, 1'b0, {3'b100, 16'h007f});
      xfer(16'h004a, 1'b0, {3'b100, 16'h0000});
      xfer(16'h004b, 1'b0, {3'b100, 16'h07ff});
      xfer(16'h004c, 1'b0, {3'b100, 16'h0000});
      xfer(16'h004d, 1'b0, {3'b100, 16'h001b});
      rst_b <= 1'b0;
      repeat (3) @(posedge mclk);
      chk({rd_ack, addr_err, wr_refused, rd_data}, 19'h00000);
      rst_b <= 1'b1;
      $display("test undefined bits done");
      // Slow client: writes refused and harmless, unmapped places flagged
      gap = 3;
      xfer(16'h0035, 1'b1, {3'b101, 16'h0000});
      xfer(16'h0035, 1'b0, {3'b100, 16'h0003});
      xfer(16'h0033, 1'b0, {3'b110, 16'h0000});
      xfer(16'h004e, 1'b0, {3'b110, 16'h0000});
      xfer(16'h0050, 1'b1, {3'b111, 16'h0000});
      $display("test refusals done");
      print_verdict;
   end
endmodule // testbench
`default_nettype wire

bind filter_status_register_bank filter_status_checker filter_status_checker_inst (
   .mclk(mclk), .rst_b(rst_b), .mm_enable(mm_enable), .master_present(master_present),
   .own_node_identifier(own_node_identifier), .nodes_running_in(nodes_running_in),
   .reg_addr(reg_addr), .rd_req(rd_req), .wr_req(wr_req), .rd_ack(rd_ack),
   .rd_data(rd_data), .addr_err(addr_err), .wr_refused(wr_refused));
